/* adcss_pkg.sv */
// Purpose: shared constants and types of the scan-mode converter sequencer
// Assumes: 32-bit AXI4-Lite register window with an 8-bit byte address
// Notes:   offsets are byte addresses, one aligned word per register
`default_nettype none

package adcss_pkg;

    // bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned AXI_DW = 32;
    localparam int unsigned STRB_W = AXI_DW / 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00; // conv_ctrl_stat_reg
    localparam logic [ADDR_W-1:0] OFF_STAT   = 8'h04; // sticky event status, read only
    localparam logic [ADDR_W-1:0] OFF_ICLR   = 8'h08; // write one to clear, write only
    localparam logic [ADDR_W-1:0] OFF_IEN    = 8'h0C; // interrupt enable
    localparam logic [ADDR_W-1:0] OFF_RES0   = 8'h20; // result_reg_a, b, c, d follow
    localparam logic [ADDR_W-1:0] RES_STRIDE = 8'h04;

    // conv_ctrl_stat_reg field positions
    localparam int unsigned B_START  = 0;  // conv_start
    localparam int unsigned B_REPEAT = 1;  // repeat_select
    localparam int unsigned B_MULTI  = 2;  // group_conv_select
    localparam int unsigned B_GROUP  = 3;  // group_sel
    localparam int unsigned B_CHHI   = 4;  // chan_sel_hi
    localparam int unsigned B_CHLO   = 5;  // chan_sel_lo
    localparam int unsigned B_TRIGEN = 6;  // external trigger enable
    localparam int unsigned B_BUSY   = 8;  // read only: sequencer running
    localparam int unsigned B_CUR    = 9;  // read only: 3-bit channel in work
    localparam int unsigned CHAN_W   = 3;

    // interrupt layout shared by status, clear and enable
    localparam int unsigned IRQ_W   = 1;
    localparam int unsigned IRQ_END = 0;   // conv_end_flag / conv_irq_enable

    // channel map
    localparam logic [CHAN_W-1:0] CH_BASE_G0 = 3'h2; // analog_input_2
    localparam logic [CHAN_W-1:0] CH_BASE_G1 = 3'h4; // analog_input_4
    localparam int unsigned NUM_RES = 4;
    localparam int unsigned POS_W   = 2;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_LAUNCH = 3'b010,
        ST_WAIT   = 3'b100
    } adcss_state_t;

endpackage

`default_nettype wire

/* adcss_irq.sv */
// Purpose: sticky event status, enable mask and one level interrupt
// Assumes: event, clear and enable strobes are single-cycle and synchronous
// Notes:   an event in the cycle of its clear keeps the bit set
`default_nettype none

module adcss_irq
    import adcss_pkg::*;
#(
    parameter int unsigned W = IRQ_W
)(
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // events and software strobes
    input  wire logic [W-1:0] evt,
    input  wire logic         clr_wr,
    input  wire logic [W-1:0] clr_data,
    input  wire logic         en_wr,
    input  wire logic [W-1:0] en_data,
    // state out
    output logic      [W-1:0] status,
    output logic      [W-1:0] enable,
    output logic              irq
);

    typedef struct packed {
        logic [W-1:0] status;
        logic [W-1:0] enable;
    } adcss_irq_regs_t;

    adcss_irq_regs_t s;
    adcss_irq_regs_t next_s;

    // set beats clear, so a pass ending during the clear write is not lost
    always_comb
    begin
        next_s = s;
        if (clr_wr)
        begin
            next_s.status = s.status & ~clr_data;
        end
        next_s.status = next_s.status | evt;
        if (en_wr)
        begin
            next_s.enable = en_data;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s <= '0;
        else
            s <= next_s;
    end

    assign status = s.status;
    assign enable = s.enable;
    assign irq    = |(s.status & s.enable);

endmodule

`default_nettype wire

/* adcss_trig.sv */
// Purpose: rising-edge detector for the external conversion trigger
// Assumes: trigger pin already synchronous to aclk
// Notes:   a level held high gives one start, not a stream of them
`default_nettype none

module adcss_trig
    import adcss_pkg::*;
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // trigger
    input  wire logic trig_in,
    input  wire logic trig_en,
    output logic      trig_pulse
);

    typedef struct packed {
        logic prev;
    } adcss_trig_regs_t;

    adcss_trig_regs_t s;
    adcss_trig_regs_t next_s;

    // remember last level for edge detection
    always_comb
    begin
        next_s      = s;
        next_s.prev = trig_in;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s <= '0;
        else
            s <= next_s;
    end

    assign trig_pulse = trig_en & trig_in & ~s.prev;

endmodule

`default_nettype wire

/* adcss_top.sv */
// Purpose: scan-mode sequencer for an external converter, AXI4-Lite slave
// Assumes: converter takes conv_launch, answers once with conv_done and data
// Notes:   one conversion outstanding; a done seen after a stop is dropped
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`default_nettype none

// Operation
// - scan mode converts selected channels cyclically, nonstop
// - start begins at group's first channel
// - next channel starts right after previous ends
// - each result goes to its channel's register
// - group one, selection two converts channels 4-6
// - pass end sets flag, restarts first channel
// - flag raises interrupt when enable is set
// - passes repeat while start set, stop otherwise
// - restart always begins at group's first channel
// - one write sets start and changes selection
module adcss_top
    import adcss_pkg::*;
#(
    parameter int unsigned DATA_W = 10
)(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [AXI_DW-1:0] s_axi_wdata,
    input  wire logic [STRB_W-1:0] s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [AXI_DW-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // converter side
    output logic                   conv_launch,
    output logic [CHAN_W-1:0]      conv_chan,
    input  wire logic              conv_done,
    input  wire logic [DATA_W-1:0] conv_data,
    // external trigger and interrupt
    input  wire logic              ext_trig,
    output logic                   conv_end_irq
);

    typedef struct packed {
        adcss_state_t                   st;
        logic                           start;
        logic                           repeat_sel;
        logic                           multi;
        logic                           group_sel;
        logic                           chan_sel_hi;
        logic                           chan_sel_lo;
        logic                           trig_en;
        logic [POS_W-1:0]               pos;
        logic [CHAN_W-1:0]              chan;
        logic [NUM_RES-1:0][DATA_W-1:0] res;
        logic                           aw_held;
        logic                           w_held;
        logic [ADDR_W-1:0]              aw_addr;
        logic [AXI_DW-1:0]              wdata;
        logic [STRB_W-1:0]              wstrb;
        logic                           bvalid;
        logic [1:0]                     bresp;
        logic                           rvalid;
        logic [AXI_DW-1:0]              rdata;
        logic [1:0]                     rresp;
    } adcss_regs_t;

    adcss_regs_t s;
    adcss_regs_t next_s;

    logic [CHAN_W-1:0] base_chan;
    logic [CHAN_W-1:0] first_chan;
    logic [POS_W-1:0]  last_pos;
    logic [POS_W-1:0]  res_idx;
    logic              take_done;
    logic              pass_end;
    logic              wrap;
    logic              wr_fire;
    logic              wr_ctrl;
    logic              wr_iclr;
    logic              wr_ien;
    logic              wr_hit;
    logic              trig_pulse;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_enable;
    logic [IRQ_W-1:0]  end_evt;

    // channel geometry from the live selection bits
    assign base_chan  = s.group_sel ? CH_BASE_G1 : CH_BASE_G0;
    assign first_chan = s.multi ? base_chan
                      : base_chan + {1'b0, s.chan_sel_hi, s.chan_sel_lo};
    assign last_pos   = s.multi ? {s.chan_sel_hi, s.chan_sel_lo} : '0;
    assign res_idx    = POS_W'(s.chan - base_chan);

    // conversion accepted only while running; a stop drops late answers
    assign take_done = (s.st == ST_WAIT) && s.start && conv_done;
    assign pass_end  = take_done && (s.pos == last_pos);
    assign wrap      = pass_end && s.multi && s.repeat_sel;

    // register write decode from the held address
    assign wr_fire = s.aw_held && s.w_held && !s.bvalid;
    assign wr_ctrl = wr_fire && (s.aw_addr == OFF_CTRL) && s.wstrb[0];
    assign wr_iclr = wr_fire && (s.aw_addr == OFF_ICLR) && s.wstrb[0];
    assign wr_ien  = wr_fire && (s.aw_addr == OFF_IEN) && s.wstrb[0];
    assign wr_hit  = (s.aw_addr == OFF_CTRL) || (s.aw_addr == OFF_STAT)
                  || (s.aw_addr == OFF_ICLR) || (s.aw_addr == OFF_IEN)
                  || ((s.aw_addr >= OFF_RES0) && (s.aw_addr[1:0] == 2'h0)
                      && (s.aw_addr < OFF_RES0 + ADDR_W'(NUM_RES) * RES_STRIDE));

    assign end_evt = IRQ_W'(pass_end) << IRQ_END;

    adcss_trig u_trig (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .trig_in    (ext_trig),
        .trig_en    (s.trig_en),
        .trig_pulse (trig_pulse)
    );

    adcss_irq #(
        .W (IRQ_W)
    ) u_irq (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .evt      (end_evt),
        .clr_wr   (wr_iclr),
        .clr_data (s.wdata[IRQ_W-1:0]),
        .en_wr    (wr_ien),
        .en_data  (s.wdata[IRQ_W-1:0]),
        .status   (irq_status),
        .enable   (irq_enable),
        .irq      (conv_end_irq)
    );

    // bus slave, control bits and sequencer in one next-state pass
    always_comb
    begin
        logic [AXI_DW-1:0] rd;
        logic              rd_hit;
        rd     = '0;
        rd_hit = 1'b0;
        next_s = s;

        // write channels, taken in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_s.w_held = 1'b1;
            next_s.wdata  = s_axi_wdata;
            next_s.wstrb  = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (s.bvalid && s_axi_bready)
        begin
            next_s.bvalid = 1'b0;
        end

        // all selection bits and start land in the same cycle
        if (wr_ctrl)
        begin
            next_s.start       = s.wdata[B_START];
            next_s.repeat_sel  = s.wdata[B_REPEAT];
            next_s.multi       = s.wdata[B_MULTI];
            next_s.group_sel   = s.wdata[B_GROUP];
            next_s.chan_sel_hi = s.wdata[B_CHHI];
            next_s.chan_sel_lo = s.wdata[B_CHLO];
            next_s.trig_en     = s.wdata[B_TRIGEN];
        end

        // read path, answered one cycle after the address
        if (s_axi_araddr == OFF_CTRL)
        begin
            rd_hit            = 1'b1;
            rd[B_START]       = s.start;
            rd[B_REPEAT]      = s.repeat_sel;
            rd[B_MULTI]       = s.multi;
            rd[B_GROUP]       = s.group_sel;
            rd[B_CHHI]        = s.chan_sel_hi;
            rd[B_CHLO]        = s.chan_sel_lo;
            rd[B_TRIGEN]      = s.trig_en;
            rd[B_BUSY]        = (s.st != ST_IDLE);
            rd[B_CUR+:CHAN_W] = s.chan;
        end
        else if (s_axi_araddr == OFF_STAT)
        begin
            rd_hit           = 1'b1;
            rd[IRQ_W-1:0]    = irq_status;
        end
        else if (s_axi_araddr == OFF_ICLR)
        begin
            rd_hit = 1'b1; // write only, reads zero
        end
        else if (s_axi_araddr == OFF_IEN)
        begin
            rd_hit           = 1'b1;
            rd[IRQ_W-1:0]    = irq_enable;
        end
        for (int k = 0; k < NUM_RES; k++)
        begin
            if (s_axi_araddr == OFF_RES0 + ADDR_W'(k) * RES_STRIDE)
            begin
                rd_hit         = 1'b1;
                rd[DATA_W-1:0] = s.res[k];
            end
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd;
            next_s.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (s.rvalid && s_axi_rready)
        begin
            next_s.rvalid = 1'b0;
        end

        // sequencer
        unique case (s.st)
            ST_IDLE:
            begin
                if (s.start)
                begin
                    next_s.st   = ST_LAUNCH;
                    next_s.pos  = '0;
                    next_s.chan = first_chan;
                end
            end
            ST_LAUNCH:
            begin
                next_s.st = s.start ? ST_WAIT : ST_IDLE;
            end
            ST_WAIT:
            begin
                if (!s.start)
                begin
                    next_s.st = ST_IDLE;
                end
                else if (conv_done)
                begin
                    next_s.res[res_idx] = conv_data;
                    if (wrap)
                    begin
                        next_s.st   = ST_LAUNCH;
                        next_s.pos  = '0;
                        next_s.chan = first_chan;
                    end
                    else if (pass_end)
                    begin
                        next_s.st    = ST_IDLE;
                        next_s.start = wr_ctrl && s.wdata[B_START]; // one pass, a write wins
                    end
                    else
                    begin
                        next_s.st   = ST_LAUNCH;
                        next_s.pos  = s.pos + 1'b1;
                        next_s.chan = s.chan + 1'b1;
                    end
                end
            end
        endcase

        // hardware trigger wins over a software clear in the same cycle
        if (trig_pulse)
        begin
            next_s.start = 1'b1;
        end
    end

    // state register, synchronous reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s    <= '0;
            s.st <= ST_IDLE;
        end
        else
        begin
            s <= next_s;
        end
    end

    // handshake outputs, one write and one read in flight
    assign s_axi_awready = !s.aw_held && !s.bvalid;
    assign s_axi_wready  = !s.w_held && !s.bvalid;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;
    assign conv_launch   = (s.st == ST_LAUNCH);
    assign conv_chan     = s.chan;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_start_launch: assert property ((s.st == ST_IDLE) && s.start
        |=> conv_launch && (conv_chan == $past(first_chan)))
        else $error("start did not launch the group's first channel");

    a_next_chan: assert property (take_done && !pass_end
        |=> conv_launch && (conv_chan == $past(s.chan) + 1'b1))
        else $error("next channel not launched right after done");

    a_result_store: assert property (take_done
        |=> s.res[$past(res_idx)] == $past(conv_data))
        else $error("result not stored in its channel register");

    a_group_three: assert property (conv_launch && s.multi && s.group_sel
        && s.chan_sel_hi && !s.chan_sel_lo
        |-> (conv_chan == CH_BASE_G1 + CHAN_W'(s.pos)) && (s.pos <= last_pos))
        else $error("three-channel group walks wrong channels");

    a_scan_wrap: assert property (wrap && !wr_ctrl
        |=> conv_launch && (conv_chan == $past(first_chan))
            ##1 ((s.st == ST_WAIT) || !$past(s.start)))
        else $error("scan pass did not wrap to first channel");

    a_end_flag: assert property (pass_end
        |=> irq_status[IRQ_END])
        else $error("end flag not set at pass end");

    a_irq_raise: assert property (pass_end && irq_enable[IRQ_END] && !wr_ien
        |=> conv_end_irq)
        else $error("interrupt not raised with enable set");

    a_stop_halt: assert property (!s.start && (s.st != ST_IDLE)
        |=> (s.st == ST_IDLE) && !conv_launch)
        else $error("sequencer kept running after start cleared");

    a_flag_sticky: assert property (irq_status[IRQ_END]
        && !(wr_iclr && s.wdata[IRQ_END]) |=> irq_status[IRQ_END])
        else $error("end flag dropped without a clear");

    a_ctrl_atomic: assert property (wr_ctrl && s.wdata[B_START]
        |=> s.start && (s.group_sel == $past(s.wdata[B_GROUP]))
            && (s.multi == $past(s.wdata[B_MULTI])))
        else $error("start and selection not taken in one write");

    c_scan_wrap:  cover property (wrap ##[1:40] wrap);
    c_restart:    cover property (s.start ##1 !s.start ##[1:20] s.start);
    c_irq_fire:   cover property (pass_end ##1 conv_end_irq);
    c_trig_start: cover property (trig_pulse && (s.st == ST_IDLE));

endmodule

`default_nettype wire

/* adcss_conv_model.sv */
// Purpose: behavioural converter answering each launch once
// Assumes: lat sets extra wait cycles before conv_done
// Notes:   conv_data toggles outside the done cycle, so stale data never looks valid
`default_nettype none

module adcss_conv_model
    import adcss_pkg::*;
(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // converter handshake
    input  wire logic              conv_launch,
    input  wire logic [CHAN_W-1:0] conv_chan,
    input  wire logic [3:0]        lat,
    output logic                   conv_done,
    output logic [9:0]             conv_data
);
    logic              busy;
    logic [3:0]        cnt;
    logic [CHAN_W-1:0] chan;

    // one done per launch, result derived from the channel
    always @(posedge aclk)
    begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (!aresetn)
        begin
            busy      <= 1'b0;
            cnt       <= 4'h0;
            conv_data <= 10'h000;
        end
        else if (conv_launch)
        begin
            busy <= 1'b1;
            cnt  <= lat;
            chan <= conv_chan;
        end
        else if (busy && cnt == 4'h0)
        begin
            busy      <= 1'b0;
            conv_done <= 1'b1;
            conv_data <= 10'h150 + 10'(chan);
        end
        else if (busy)
            cnt <= cnt - 4'h1;
    end
endmodule

`default_nettype wire

/* adcss_top_bench.sv */
// Purpose: self-checking bench of the scan sequencer
// Assumes: converter model answers every launch lat + 2 cycles after the launch pulse
// Notes:   launches are logged by channel; software stops before reselecting
`default_nettype none

module adcss_top_bench
    import adcss_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic aclk, aresetn, awv, awr, wv, wr_, bv, brdy, arv, arr, rv, rrdy;
    logic launch, done, trig, irq;
    logic [ADDR_W-1:0] awa, ara;
    logic [31:0]       wd, rd;
    logic [1:0]        br, rr, resp;
    logic [CHAN_W-1:0] chan;
    logic [9:0]        cdata;
    logic [3:0]        lat;
    logic [CHAN_W-1:0] log_q[$];
    int                n_fail, compares;

    adcss_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .conv_launch(launch),
        .conv_chan(chan), .conv_done(done), .conv_data(cdata), .ext_trig(trig),
        .conv_end_irq(irq));

    adcss_conv_model conv (.aclk(aclk), .aresetn(aresetn), .conv_launch(launch),
        .conv_chan(chan), .lat(lat), .conv_done(done), .conv_data(cdata));

    // clock, 50 MHz
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // launch log, channel valid with the launch pulse
    always @(posedge aclk)
        if (launch === 1'b1)
            log_q.push_back(chan);

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awa  <= a;
        wd   <= d;
        awv  <= 1'b1;
        wv   <= 1'b1;
        brdy <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_) wv <= 1'b0;
            n++;
        end while (bv !== 1'b1 && n < 100);
        if (n >= 100) n_fail++;
        resp = br;
        brdy <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rdr(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        int n;
        n = 0;
        ara  <= a;
        arv  <= 1'b1;
        rrdy <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arv && arr) arv <= 1'b0;
            n++;
        end while (rv !== 1'b1 && n < 100);
        if (n >= 100) n_fail++;
        d    = rd;
        resp = rr;
        rrdy <= 1'b0;
        @(posedge aclk);
    endtask

    // bounded wait for a number of logged launches
    task automatic wait_launch(input int n);
        int i;
        i = 0;
        while (log_q.size() < n && i < 500)
        begin
            @(posedge aclk);
            i++;
        end
        chk("launch count", 32'(log_q.size() >= n), 32'h1);
    endtask

    task automatic s_regs();
        logic [31:0] d;
        rdr(OFF_CTRL, d);
        chk("ctrl reset", d, 32'h0);
        rdr(OFF_STAT, d);
        chk("status reset", d, 32'h0);
        rdr(8'h40, d);
        chk("unmapped read resp", 32'(resp), 32'(RESP_SLVERR));
        wr(8'h44, 32'h1);
        chk("unmapped write resp", 32'(resp), 32'(RESP_SLVERR));
    endtask

    // group 1, three channels, start in the same write as the selection
    task automatic s_scan();
        logic [31:0] d;
        logic [2:0]  exp_ch[7] = '{3'h4, 3'h5, 3'h6, 3'h4, 3'h5, 3'h6, 3'h4};
        lat <= 4'h3;
        wr(OFF_IEN, 32'h1);
        log_q.delete();
        wr(OFF_CTRL, 32'h1F);
        wait_launch(7);
        for (int i = 0; i < 7; i++)
            chk("scan channel order", 32'(log_q[i]), 32'(exp_ch[i]));
        for (int i = 0; i < 3; i++)
        begin
            rdr(OFF_RES0 + 8'(4 * i), d);
            chk("result register", d & 32'h3FF, 32'h154 + 32'(i));
        end
        rdr(OFF_STAT, d);
        chk("end flag", d, 32'h1);
        chk("irq raised", 32'(irq), 32'h1);
    endtask

    // stop, sticky flag, mask and clear, restart from the first channel
    task automatic s_stop();
        logic [31:0] d;
        int          n;
        wr(OFF_CTRL, 32'h1E);
        repeat (10) @(posedge aclk);
        n = log_q.size();
        repeat (30) @(posedge aclk);
        chk("no launch after stop", 32'(log_q.size()), 32'(n));
        rdr(OFF_STAT, d);
        chk("flag sticky", d, 32'h1);
        wr(OFF_IEN, 32'h0);
        chk("irq masked", 32'(irq), 32'h0);
        wr(OFF_IEN, 32'h1);
        wr(OFF_ICLR, 32'h1);
        rdr(OFF_STAT, d);
        chk("flag cleared", d, 32'h0);
        chk("irq cleared", 32'(irq), 32'h0);
        lat <= 4'h0;
        log_q.delete();
        wr(OFF_CTRL, 32'h1F);
        wait_launch(1);
        chk("restart channel", 32'(log_q[0]), 32'h4);
        wr(OFF_CTRL, 32'h1E);
    endtask

    // group 0 two channels, then start from the external trigger
    task automatic s_group0_trig();
        logic [31:0] d;
        repeat (10) @(posedge aclk);
        log_q.delete();
        wr(OFF_CTRL, 32'h27);
        wait_launch(3);
        chk("group 0 first", 32'(log_q[0]), 32'h2);
        chk("group 0 second", 32'(log_q[1]), 32'h3);
        chk("group 0 wrap", 32'(log_q[2]), 32'h2);
        wr(OFF_CTRL, 32'h66);
        repeat (10) @(posedge aclk);
        log_q.delete();
        trig <= 1'b1;
        wait_launch(1);
        chk("trigger start channel", 32'(log_q[0]), 32'h2);
        trig <= 1'b0;
        wr(OFF_CTRL, 32'h26);
        // multi without repeat: one pass, then start drops by itself
        repeat (10) @(posedge aclk);
        log_q.delete();
        wr(OFF_CTRL, 32'h25);
        wait_launch(2);
        repeat (30) @(posedge aclk);
        chk("one pass launches", 32'(log_q.size()), 32'h2);
        rdr(OFF_CTRL, d);
        chk("start and busy after pass", d & 32'h101, 32'h0);
    endtask

    // watchdog well beyond the expected run
    initial
    begin
        #200us;
        n_fail++;
        end_of_test();
    end

    initial
    begin
        n_fail   = 0;
        compares = 0;
        aresetn  = 1'b0;
        {awv, wv, brdy, arv, rrdy, trig} = 6'h00;
        awa = 8'h00;
        ara = 8'h00;
        wd  = 32'h0;
        lat = 4'h2;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        s_regs();
        s_scan();
        s_stop();
        s_group0_trig();
        end_of_test();
    end
endmodule

`default_nettype wire
